// ---- core/wdk_ctrl.sv ----
// Watchdog control register, service and idle key checking, timeout
// counter and pin, with a Wishbone slave and an interrupt output.
// Assumes one clock, synchronous reset, and a classic Wishbone master.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module wdk_ctrl
  import wdk_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wdt_out,
  output logic idle_permit,
  output logic irq
);
  typedef struct packed {
    wdk_state_t st;
    logic [15:0] key;
    logic flag;
    logic [1:0] ikey;
    logic idle_ok;
    logic [1:0] mode;
    logic [CNT_W-1:0] prd;
    logic [CNT_W-1:0] cnt;
    logic [WDK_IRQ_W-1:0] sts;
    logic [WDK_IRQ_W-1:0] ien;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic pin;
  } wdk_regs_t;

  wdk_regs_t r;
  wdk_regs_t n;

  logic acc;
  logic wr;
  logic [4:0] ofs;
  logic wdt_mode;
  logic armed;
  logic ctrl_wr;
  logic key_wr;
  logic ikey_wr;
  logic key_done;
  logic key_bad;
  logic ikey_done;
  logic cnt_hit;
  logic tmo;
  logic [WDK_IRQ_W-1:0] sts_set;
  logic [31:0] rd;

  assign acc = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr = acc && wb_we_i;
  assign ofs = {wb_adr_i[4:2], 2'b00};
  assign wdt_mode = (r.mode == WDK_MODE_WDT);
  assign armed = (r.st != wdk_st_init);
  assign ctrl_wr = wr && ofs == WDK_OFS_CTRL && wb_sel_i[1];
  // Key fields are only seen in watchdog mode and on whole-field writes.
  assign key_wr = wr && ofs == WDK_OFS_CTRL && wb_sel_i[3] && wb_sel_i[2]
                  && wdt_mode;
  assign ikey_wr = ctrl_wr && wdt_mode;
  assign cnt_hit = (r.st == wdk_st_act) && (r.cnt >= r.prd);
  assign tmo = (armed && key_bad) || cnt_hit;

  wdk_keyseq #(
    .W(16)
  ) u_service (
    .clk(clk),
    .reset(reset),
    .wr(key_wr),
    .val(wb_dat_i[WDK_KEY_HI:WDK_KEY_LO]),
    .first(WDK_KEY_FIRST),
    .second(WDK_KEY_SECOND),
    .done(key_done),
    .bad(key_bad)
  );

  wdk_keyseq #(
    .W(2)
  ) u_idle (
    .clk(clk),
    .reset(reset),
    .wr(ikey_wr),
    .val(wb_dat_i[WDK_IKEY_HI:WDK_IKEY_LO]),
    .first(WDK_IKEY_FIRST),
    .second(WDK_IKEY_SECOND),
    .done(ikey_done),
    .bad()
  );

  always_comb begin
    sts_set = '0;
    sts_set[WDK_IRQ_TMO] = tmo;
    sts_set[WDK_IRQ_SVC] = armed && key_done;
    sts_set[WDK_IRQ_VIOL] = armed && key_bad;
  end

  // Control register bits 11 to 0 are never stored, so they read back as zero.
  always_comb begin
    rd = 32'h00000000;
    case (ofs)
      WDK_OFS_CTRL: begin
        rd[WDK_KEY_HI:WDK_KEY_LO] = r.key;
        rd[WDK_FLAG_BIT] = r.flag;
        rd[WDK_ARM_BIT] = armed;
        rd[WDK_IKEY_HI:WDK_IKEY_LO] = r.ikey;
      end
      WDK_OFS_MODE: rd[WDK_MODE_HI:WDK_MODE_LO] = r.mode;
      WDK_OFS_PRD: rd[CNT_W-1:0] = r.prd;
      WDK_OFS_CNT: rd[CNT_W-1:0] = r.cnt;
      WDK_OFS_STS: rd[WDK_IRQ_W-1:0] = r.sts;
      WDK_OFS_IEN: rd[WDK_IRQ_W-1:0] = r.ien;
      default: rd = 32'h00000000;
    endcase
  end

  always_comb begin
    n = r;
    n.pin = 1'b0;
    n.ack = acc;
    n.dat = (acc && !wb_we_i) ? rd : 32'h00000000;
    // The counter runs in every state; only a service pulls it back.
    n.cnt = r.cnt + 1'b1;
    if (key_wr) begin
      n.key = wb_dat_i[WDK_KEY_HI:WDK_KEY_LO];
    end
    if (ikey_wr) begin
      n.ikey = wb_dat_i[WDK_IKEY_HI:WDK_IKEY_LO];
    end
    // Mode and period are write protected while armed.
    if (wr && !armed && ofs == WDK_OFS_MODE && wb_sel_i[0]) begin
      n.mode = wb_dat_i[WDK_MODE_HI:WDK_MODE_LO];
    end
    if (wr && !armed && ofs == WDK_OFS_PRD && (&wb_sel_i)) begin
      n.prd = wb_dat_i[CNT_W-1:0];
    end
    if (wr && ofs == WDK_OFS_IEN && wb_sel_i[0]) begin
      n.ien = wb_dat_i[WDK_IRQ_W-1:0];
    end
    if (ctrl_wr && wb_dat_i[WDK_FLAG_BIT]) begin
      n.flag = 1'b0;
    end
    case (r.st)
      wdk_st_init: begin
        if (ctrl_wr && wdt_mode && wb_dat_i[WDK_ARM_BIT]) begin
          n.st = wdk_st_pre;
        end
      end
      wdk_st_pre: begin
        if (key_done) begin
          n.st = wdk_st_act;
          n.flag = 1'b0;
        end
      end
      wdk_st_act: n.st = wdk_st_act;
      default: n.st = wdk_st_init;
    endcase
    if (armed && key_done) begin
      n.cnt = '0;
    end
    // A timeout disarms and wins over any flag clear in the same cycle.
    if (tmo) begin
      n.st = wdk_st_init;
      n.flag = 1'b1;
      n.pin = 1'b1;
    end
    if (ikey_done) begin
      n.idle_ok = 1'b1;
    end
    if (ikey_wr && wb_dat_i[WDK_IKEY_HI:WDK_IKEY_LO] == WDK_IKEY_BLOCK) begin
      n.idle_ok = 1'b0;
    end
    n.sts = r.sts;
    if (wr && ofs == WDK_OFS_CLR && wb_sel_i[0]) begin
      n.sts = r.sts & ~wb_dat_i[WDK_IRQ_W-1:0];
    end
    n.sts = n.sts | sts_set;
    n.irq = |(n.sts & n.ien);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.st <= wdk_st_init;
      r.key <= WDK_KEY_RST;
      r.mode <= WDK_MODE_RST;
      r.prd <= WDK_PRD_RST[CNT_W-1:0];
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign wdt_out = r.pin;
  assign idle_permit = r.idle_ok;
  assign irq = r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_armed_break;
    armed && key_bad;
  endsequence

  sequence s_trip;
    wdt_out && r.st == wdk_st_init && r.flag ##1 !wdt_out;
  endsequence

  property p_service_activates;
    (r.st == wdk_st_pre && key_done && !tmo) |=>
      r.st == wdk_st_act && !r.flag;
  endproperty
  a_service_activates: assert property (p_service_activates)
    else $error("Completed key sequence did not activate watchdog.");

  property p_break_trips;
    s_armed_break |=> s_trip;
  endproperty
  a_break_trips: assert property (p_break_trips)
    else $error("Broken key sequence did not trip watchdog at once.");

  property p_key_inert;
    !wdt_mode |=> r.key == $past(r.key) && r.ikey == $past(r.ikey);
  endproperty
  a_key_inert: assert property (p_key_inert)
    else $error("Key field changed outside watchdog mode.");

  property p_flag_clear;
    (ctrl_wr && wb_dat_i[WDK_FLAG_BIT] && !tmo) |=> !r.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Writing one did not clear the timeout flag.");

  property p_init_holds;
    (r.st == wdk_st_init && !(ctrl_wr && wb_dat_i[WDK_ARM_BIT])) |=>
      r.st == wdk_st_init;
  endproperty
  a_init_holds: assert property (p_init_holds)
    else $error("Watchdog left initial state without arm bit.");

  property p_pin_isolated;
    !armed |=> !wdt_out;
  endproperty
  a_pin_isolated: assert property (p_pin_isolated)
    else $error("Watchdog pin pulsed while disarmed.");

  property p_timeout_pin;
    (r.st == wdk_st_act && r.cnt >= r.prd) |=> wdt_out && r.flag;
  endproperty
  a_timeout_pin: assert property (p_timeout_pin)
    else $error("Counter timeout did not reach the pin.");

  property p_stay_armed;
    (armed && !tmo) |=> armed;
  endproperty
  a_stay_armed: assert property (p_stay_armed)
    else $error("Watchdog disarmed without timeout or reset.");

  property p_idle_permit;
    ikey_done |=> idle_permit;
  endproperty
  a_idle_permit: assert property (p_idle_permit)
    else $error("Idle key sequence did not permit idle.");

  property p_idle_block;
    (ikey_wr && wb_dat_i[WDK_IKEY_HI:WDK_IKEY_LO] == WDK_IKEY_BLOCK)
      |=> !idle_permit;
  endproperty
  a_idle_block: assert property (p_idle_block)
    else $error("Idle key 00b did not block idle.");

  property p_low_zero;
    (acc && !wb_we_i && ofs == WDK_OFS_CTRL) |=>
      wb_ack_o && wb_dat_o[11:0] == 12'h000;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("Reserved control bits read nonzero.");

  property p_mode_gate;
    (r.st == wdk_st_init && !wdt_mode) |=> r.st == wdk_st_init;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("Watchdog armed outside watchdog mode.");

  property p_restart;
    (armed && key_done && !tmo) |=> r.cnt == '0 ##1 r.cnt == 1;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Service did not restart the count.");
endmodule

// ---- include/wdk_pkg.sv ----
// Shared constants and types of the watchdog control and key logic.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package wdk_pkg;
  // Byte offsets of the registers.
  localparam logic [4:0] WDK_OFS_CTRL = 5'h00;
  localparam logic [4:0] WDK_OFS_MODE = 5'h04;
  localparam logic [4:0] WDK_OFS_PRD = 5'h08;
  localparam logic [4:0] WDK_OFS_CNT = 5'h0C;
  localparam logic [4:0] WDK_OFS_STS = 5'h10;
  localparam logic [4:0] WDK_OFS_CLR = 5'h14;
  localparam logic [4:0] WDK_OFS_IEN = 5'h18;
  // Field positions of the watchdog control register and the mode register.
  localparam int WDK_KEY_HI = 31;
  localparam int WDK_KEY_LO = 16;
  localparam int WDK_FLAG_BIT = 15;
  localparam int WDK_ARM_BIT = 14;
  localparam int WDK_IKEY_HI = 13;
  localparam int WDK_IKEY_LO = 12;
  localparam int WDK_MODE_HI = 3;
  localparam int WDK_MODE_LO = 2;
  // Key values and mode code.
  localparam logic [15:0] WDK_KEY_FIRST = 16'hA5C6;
  localparam logic [15:0] WDK_KEY_SECOND = 16'hDA7E;
  localparam logic [1:0] WDK_IKEY_FIRST = 2'h1;
  localparam logic [1:0] WDK_IKEY_SECOND = 2'h2;
  localparam logic [1:0] WDK_IKEY_BLOCK = 2'h0;
  localparam logic [1:0] WDK_MODE_WDT = 2'h2;
  // Reset values.
  localparam logic [15:0] WDK_KEY_RST = 16'h0000;
  localparam logic [1:0] WDK_MODE_RST = 2'h0;
  localparam logic [31:0] WDK_PRD_RST = 32'h0000FFFF;
  // Interrupt status bit positions and width.
  localparam int WDK_IRQ_TMO = 0;
  localparam int WDK_IRQ_SVC = 1;
  localparam int WDK_IRQ_VIOL = 2;
  localparam int WDK_IRQ_W = 3;
  typedef enum logic [1:0] {
    wdk_st_init,
    wdk_st_pre,
    wdk_st_act
  } wdk_state_t;
endpackage

// ---- core/wdk_keyseq.sv ----
// Two-step key sequence detector for one key field.
// Assumes wr is a one-cycle write strobe on clk with val valid with it.
`timescale 1ns/100ps
module wdk_keyseq #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic [W-1:0] val,
  input wire logic [W-1:0] first,
  input wire logic [W-1:0] second,
  output logic done,
  output logic bad
);
  typedef struct packed {
    logic expect_second;
  } wdk_seq_t;

  wdk_seq_t r;
  wdk_seq_t n;

  // A repeated first value restarts the sequence rather than breaking it.
  always_comb begin
    n = r;
    done = 1'b0;
    bad = 1'b0;
    if (wr) begin
      if (val == first) begin
        n.expect_second = 1'b1;
      end else if (r.expect_second && val == second) begin
        n.expect_second = 1'b0;
        done = 1'b1;
      end else begin
        n.expect_second = 1'b0;
        bad = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// ---- dv/wdk_ctrl_tb_top.sv ----
// Self-checking bench of the watchdog control and key logic.
// Assumes wdk_pkg and wdk_ctrl are compiled first; the bench is the master.
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module wdk_ctrl_tb_top
  import wdk_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic wdt_out;
  logic idle_permit;
  logic irq;
  logic [31:0] rd;
  logic [31:0] c0;
  int err_total = 0;
  int n_compared = 0;
  int pulses = 0;

  wdk_ctrl dut (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .wdt_out(wdt_out),
    .idle_permit(idle_permit), .irq(irq)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // One count per cycle that the pin is high, so a stretched pulse shows.
  always @(posedge clk) begin
    if (wdt_out === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    `CHK(ack, 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask

  task automatic rdv(input logic [4:0] a, output logic [31:0] q);
    wb(1'b0, a, 4'hF, 32'h0, q);
  endtask

  // Only the key bytes are enabled, so flag and arm are left alone.
  task automatic svc;
    wr(WDK_OFS_CTRL, 4'hC, {WDK_KEY_FIRST, 16'h0000});
    wr(WDK_OFS_CTRL, 4'hC, {WDK_KEY_SECOND, 16'h0000});
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({wdt_out, idle_permit, irq, ack}, 4'h0);
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd, 32'h0);
    // General-purpose mode: keys, arm and reserved bits do nothing.
    wr(WDK_OFS_CTRL, 4'hF, {WDK_KEY_FIRST, 16'h5FFF});
    wr(WDK_OFS_CTRL, 4'hF, {WDK_KEY_SECOND, 16'h6FFF});
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd, 32'h0);
    `CHK(idle_permit, 1'b0);
    wr(WDK_OFS_MODE, 4'hF, 32'h0000_0008);
    wr(WDK_OFS_PRD, 4'hF, 32'h0000_003C);
    wr(WDK_OFS_IEN, 4'hF, 32'h0000_0007);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_4000);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_0000);
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[14], 1'b1);
    svc();
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[31:14], {WDK_KEY_SECOND, 2'h1});
    `CHK(pulses, 0);
    repeat (20) @(posedge clk);
    wr(WDK_OFS_CTRL, 4'hC, {WDK_KEY_FIRST, 16'h0000});
    rdv(WDK_OFS_CNT, rd);
    `CHK(rd >= 32'd20, 1'b1);
    wr(WDK_OFS_CTRL, 4'hC, {WDK_KEY_SECOND, 16'h0000});
    rdv(WDK_OFS_CNT, rd);
    `CHK(rd < 32'd8, 1'b1);
    wr(WDK_OFS_CTRL, 4'hC, 32'h1234_0000);
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[15:14], 2'h2);
    `CHK(pulses, 1);
    `CHK(irq, 1'b1);
    rdv(WDK_OFS_STS, rd);
    `CHK(rd[2:0], 3'h7);
    // Mask the interrupt, then time out by count after a fresh service.
    wr(WDK_OFS_IEN, 4'hF, 32'h0);
    wr(WDK_OFS_CLR, 4'hF, 32'h0000_0007);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_4000);
    svc();
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[15:14], 2'h1);
    repeat (80) @(posedge clk);
    `CHK(pulses, 2);
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[15:14], 2'h2);
    `CHK(irq, 1'b0);
    wr(WDK_OFS_IEN, 4'hF, 32'h0000_0001);
    rdv(WDK_OFS_STS, rd);
    `CHK(rd[2:0], 3'h3);
    `CHK(irq, 1'b1);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_8000);
    wr(WDK_OFS_CLR, 4'hF, 32'h0000_0001);
    rdv(WDK_OFS_CTRL, rd);
    `CHK(rd[15], 1'b0);
    `CHK(irq, 1'b0);
    // Disarmed: the counter runs on and the pin stays quiet.
    repeat (80) @(posedge clk);
    wr(WDK_OFS_CTRL, 4'hC, 32'h1234_0000);
    `CHK(pulses, 2);
    rdv(WDK_OFS_CNT, c0);
    rdv(WDK_OFS_CNT, rd);
    `CHK(rd != c0, 1'b1);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_1000);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_2000);
    `CHK(idle_permit, 1'b1);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_0000);
    `CHK(idle_permit, 1'b0);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_2000);
    `CHK(idle_permit, 1'b0);
    wr(WDK_OFS_CTRL, 4'h2, 32'h0000_4000);
    wr(WDK_OFS_CTRL, 4'hC, {WDK_KEY_SECOND, 16'h0000});
    rdv(WDK_OFS_CTRL, rd);
    `CHK(pulses, 3);
    `CHK(rd[15:14], 2'h2);
    wr(5'h1C, 4'hF, 32'hFFFF_FFFF);
    rdv(5'h1C, rd);
    `CHK(rd, 32'h0);
    report_and_stop();
  end

  // The tests take under 1500 cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    report_and_stop();
  end
endmodule
